// ### pkg/scss_pkg.sv
`default_nettype none
package scss_pkg;
  // Datapath widths and stack depth
  localparam int WORD_W = 16;
  localparam int CELL_W = 17;
  localparam int CODE_W = 5;
  localparam int SLOT_W = 2;
  localparam int IRQ_W = 5;
  localparam int STACK_DEPTH = 32;

  typedef logic [WORD_W-1:0] scss_word_type;
  typedef logic [CELL_W-1:0] scss_cell_type;
  typedef logic [CODE_W-1:0] scss_code_type;
  typedef logic [SLOT_W-1:0] scss_slot_type;

  // Slot numbers
  localparam scss_slot_type SLOT_FETCH = 2'h0;
  localparam scss_slot_type SLOT_ONE = 2'h1;
  localparam scss_slot_type SLOT_TWO = 2'h2;
  localparam scss_slot_type SLOT_THREE = 2'h3;

  // Instruction word layout and cell carry bit
  localparam int CALL_FLAG_BIT = 15;
  localparam int SHIFT_ONE = 10;
  localparam int SHIFT_TWO = 5;
  localparam scss_word_type CALL_TARGET_MASK = 16'h7fff;
  localparam scss_word_type PAGE_MASK = 16'hfc00;
  localparam int CARRY_BIT = 16;

  // Reset values and unit constants
  localparam scss_word_type RESET_VECTOR = 16'h0000;
  localparam scss_cell_type CELL_ZERO = 17'h00000;
  localparam scss_word_type WORD_ONE = 16'h0001;
  localparam scss_cell_type CELL_ONE = 17'h00001;

  // Opcodes
  localparam scss_code_type BRANCH_OP = 5'h00;
  localparam scss_code_type RETURN_OP = 5'h01;
  localparam scss_code_type BRANCH_IF_ZERO_OP = 5'h02;
  localparam scss_code_type BRANCH_IF_CARRY_OP = 5'h03;
  localparam scss_code_type CALL_OP = 5'h04;
  localparam scss_code_type LOOP_NEXT_OP = 5'h05;
  localparam scss_code_type INTERRUPT_ENABLE_OP = 5'h06;
  localparam scss_code_type SWAP_OP = 5'h08;
  localparam scss_code_type LOAD_POST_INC_OP = 5'h09;
  localparam scss_code_type LOAD_INLINE_OP = 5'h0a;
  localparam scss_code_type LOAD_OP = 5'h0b;
  localparam scss_code_type STORE_POST_INC_OP = 5'h0d;
  localparam scss_code_type ROTATE_BYTE_OP = 5'h0e;
  localparam scss_code_type STORE_OP = 5'h0f;
  localparam scss_code_type COMPLEMENT_OP = 5'h10;
  localparam scss_code_type SHIFT_LEFT_OP = 5'h11;
  localparam scss_code_type SHIFT_RIGHT_OP = 5'h12;
  localparam scss_code_type MULTIPLY_STEP_OP = 5'h13;
  localparam scss_code_type XOR_OP = 5'h14;
  localparam scss_code_type AND_OP = 5'h15;
  localparam scss_code_type DIVIDE_STEP_OP = 5'h16;
  localparam scss_code_type ADD_OP = 5'h17;
  localparam scss_code_type POP_RETURN_OP = 5'h18;
  localparam scss_code_type COPY_ADDRESS_OP = 5'h19;
  localparam scss_code_type DUP_OP = 5'h1a;
  localparam scss_code_type OVER_OP = 5'h1b;
  localparam scss_code_type PUSH_RETURN_OP = 5'h1c;
  localparam scss_code_type STORE_ADDRESS_OP = 5'h1d;
  localparam scss_code_type DROP_OP = 5'h1e;
  localparam scss_code_type IDLE_OP = 5'h1f;
endpackage
`default_nettype wire

// ### hw/scss_stack.sv
`timescale 1ns/1ps
`default_nettype none
// Circular stack; top is the visible element, overflow overwrites silently
module scss_stack #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic wr,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] top
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [PTR_W-1:0] ptr_reg;
  logic [PTR_W-1:0] ptr_next;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];

  always_comb begin
    mem_next = mem_reg;
    ptr_next = ptr_reg;
    if (push) begin
      ptr_next = ptr_reg + PTR_W'(1);
      mem_next[ptr_next] = din;
    end else if (pop) begin
      ptr_next = ptr_reg - PTR_W'(1);
    end else if (wr) begin
      mem_next[ptr_reg] = din;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ptr_reg <= '0;
      for (int k = 0; k < DEPTH; k++) begin
        mem_reg[k] <= '0;
      end
    end else begin
      ptr_reg <= ptr_next;
      mem_reg <= mem_next;
    end
  end

  assign top = mem_reg[ptr_reg];
endmodule
`default_nettype wire

// ### hw/scss_core.sv
`timescale 1ns/1ps
`default_nettype none
module scss_core #(
  parameter int STACK_DEPTH = scss_pkg::STACK_DEPTH
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic [scss_pkg::WORD_W-1:0] DATA_IN,
  input wire logic [scss_pkg::IRQ_W-1:0] IRQ,
  output logic [scss_pkg::WORD_W-1:0] ADDR_BUS,
  output logic [scss_pkg::WORD_W-1:0] DATA_OUT,
  output logic WRITE_EN,
  output logic [scss_pkg::SLOT_W-1:0] SLOT,
  output logic INT_ENABLED
);
  // Picks the 5-bit code of a slot out of a program word
  function automatic scss_pkg::scss_code_type code_sel(input scss_pkg::scss_word_type w,
                                                       input scss_pkg::scss_slot_type sl);
    scss_pkg::scss_word_type sh;
    sh = w;
    unique case (sl)
      scss_pkg::SLOT_ONE: sh = w >> scss_pkg::SHIFT_ONE;
      scss_pkg::SLOT_TWO: sh = w >> scss_pkg::SHIFT_TWO;
      default: sh = w;
    endcase
    return scss_pkg::scss_code_type'(sh);
  endfunction

  // Core registers
  scss_pkg::scss_slot_type slot_reg, slot_next;
  scss_pkg::scss_word_type i_reg, i_next;
  scss_pkg::scss_word_type p_reg, p_next;
  scss_pkg::scss_cell_type a_reg, a_next;
  scss_pkg::scss_cell_type t_reg, t_next;
  logic ie_reg, ie_next;
  // Registered bus outputs
  scss_pkg::scss_word_type addr_reg, addr_next;
  scss_pkg::scss_word_type dout_reg, dout_next;
  logic wr_reg, wr_next;
  // Interrupt pin synchroniser
  logic [scss_pkg::IRQ_W-1:0] irq_s1_reg, irq_s2_reg, irq_s3_reg;
  logic [scss_pkg::IRQ_W-1:0] irq_reg, irq_next;
  // Stack controls
  logic s_push, s_pop, s_wr, r_push, r_pop, r_wr;
  scss_pkg::scss_cell_type s_din, r_din, s_top, r_top;
  // Datapath helpers
  scss_pkg::scss_code_type code, code_next;
  scss_pkg::scss_cell_type sum;
  scss_pkg::scss_cell_type mul_sel;
  scss_pkg::scss_word_type page_target;
  scss_pkg::scss_cell_type bus_cell;

  scss_stack #(.WIDTH(scss_pkg::CELL_W), .DEPTH(STACK_DEPTH)) u_param_stack (
    .clk_sys(CLK_SYS),
    .arst_n(ARST_N),
    .push(s_push),
    .pop(s_pop),
    .wr(s_wr),
    .din(s_din),
    .top(s_top)
  );

  scss_stack #(.WIDTH(scss_pkg::CELL_W), .DEPTH(STACK_DEPTH)) u_return_stack (
    .clk_sys(CLK_SYS),
    .arst_n(ARST_N),
    .push(r_push),
    .pop(r_pop),
    .wr(r_wr),
    .din(r_din),
    .top(r_top)
  );

  // Interrupt pins: a change counts once second and third stages agree
  always_comb begin
    irq_next = irq_reg;
    if (irq_s2_reg == irq_s3_reg) begin
      irq_next = irq_s3_reg;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_s1_reg <= '0;
      irq_s2_reg <= '0;
      irq_s3_reg <= '0;
      irq_reg <= '0;
    end else begin
      irq_s1_reg <= IRQ;
      irq_s2_reg <= irq_s1_reg;
      irq_s3_reg <= irq_s2_reg;
      irq_reg <= irq_next;
    end
  end

  assign code = code_sel(i_reg, slot_reg);
  assign sum = {1'b0, s_top[scss_pkg::WORD_W-1:0]} + {1'b0, t_reg[scss_pkg::WORD_W-1:0]};
  assign mul_sel = a_reg[0] ? sum : {1'b0, t_reg[scss_pkg::WORD_W-1:0]};
  assign page_target = (p_reg & scss_pkg::PAGE_MASK) | (i_reg & ~scss_pkg::PAGE_MASK);
  assign bus_cell = {1'b0, DATA_IN};

  // Decoder, stack controls and input multiplexers of the core registers
  always_comb begin
    // count up, two-bit wrap from three to zero
    slot_next = slot_reg + scss_pkg::SLOT_ONE;
    i_next = i_reg;
    p_next = p_reg;
    a_next = a_reg;
    t_next = t_reg;
    ie_next = ie_reg;
    s_push = 1'b0;
    s_pop = 1'b0;
    s_wr = 1'b0;
    s_din = t_reg;
    r_push = 1'b0;
    r_pop = 1'b0;
    r_wr = 1'b0;
    r_din = t_reg;
    if (slot_reg == scss_pkg::SLOT_FETCH) begin
      // vectored interrupt call in fetch slot
      if (irq_reg != '0 && ie_reg) begin
        r_push = 1'b1;
        r_din = {1'b0, p_reg};
        p_next = scss_pkg::scss_word_type'(irq_reg);
        ie_next = 1'b0;
        slot_next = scss_pkg::SLOT_FETCH;
      end else begin
        i_next = DATA_IN;
        p_next = p_reg + scss_pkg::WORD_ONE;
      end
    end else if (!i_reg[scss_pkg::CALL_FLAG_BIT]) begin
      r_push = 1'b1;
      r_din = {1'b0, p_reg};
      p_next = i_reg & scss_pkg::CALL_TARGET_MASK;
      slot_next = scss_pkg::SLOT_FETCH;
    end else begin
      unique case (code)
        scss_pkg::BRANCH_OP: begin
          p_next = page_target;
          slot_next = scss_pkg::SLOT_FETCH;
        end
        // return ends the word in any slot
        scss_pkg::RETURN_OP: begin
          p_next = r_top[scss_pkg::WORD_W-1:0];
          r_pop = 1'b1;
          slot_next = scss_pkg::SLOT_FETCH;
        end
        scss_pkg::BRANCH_IF_ZERO_OP: begin
          if (t_reg[scss_pkg::WORD_W-1:0] == '0) begin
            p_next = page_target;
          end
          slot_next = scss_pkg::SLOT_FETCH;
        end
        scss_pkg::BRANCH_IF_CARRY_OP: begin
          if (t_reg[scss_pkg::CARRY_BIT]) begin
            p_next = page_target;
          end
          slot_next = scss_pkg::SLOT_FETCH;
        end
        scss_pkg::CALL_OP: begin
          r_push = 1'b1;
          r_din = {1'b0, p_reg};
          p_next = page_target;
          slot_next = scss_pkg::SLOT_FETCH;
        end
        scss_pkg::LOOP_NEXT_OP: begin
          if (r_top != scss_pkg::CELL_ZERO) begin
            r_wr = 1'b1;
            r_din = r_top - scss_pkg::CELL_ONE;
            p_next = page_target;
          end else begin
            r_pop = 1'b1;
          end
          slot_next = scss_pkg::SLOT_FETCH;
        end
        // idle ends the word at no cost
        scss_pkg::IDLE_OP: begin
          slot_next = scss_pkg::SLOT_FETCH;
        end
        scss_pkg::INTERRUPT_ENABLE_OP: begin
          ie_next = 1'b1;
        end
        scss_pkg::SWAP_OP: begin
          s_wr = 1'b1;
          t_next = s_top;
        end
        // memory reads load top from bus
        scss_pkg::LOAD_POST_INC_OP: begin
          s_push = 1'b1;
          t_next = bus_cell;
          a_next = a_reg + scss_pkg::CELL_ONE;
        end
        scss_pkg::LOAD_INLINE_OP: begin
          s_push = 1'b1;
          t_next = bus_cell;
          p_next = p_reg + scss_pkg::WORD_ONE;
        end
        scss_pkg::LOAD_OP: begin
          s_push = 1'b1;
          t_next = bus_cell;
        end
        scss_pkg::STORE_POST_INC_OP: begin
          s_pop = 1'b1;
          t_next = s_top;
          a_next = a_reg + scss_pkg::CELL_ONE;
        end
        scss_pkg::STORE_OP: begin
          s_pop = 1'b1;
          t_next = s_top;
        end
        scss_pkg::ROTATE_BYTE_OP: begin
          t_next = {t_reg[scss_pkg::CARRY_BIT], t_reg[7:0], t_reg[15:8]};
        end
        scss_pkg::COMPLEMENT_OP: begin
          t_next = {t_reg[scss_pkg::CARRY_BIT], ~t_reg[scss_pkg::WORD_W-1:0]};
        end
        scss_pkg::SHIFT_LEFT_OP: begin
          t_next = {t_reg[scss_pkg::WORD_W-1:0], 1'b0};
        end
        scss_pkg::SHIFT_RIGHT_OP: begin
          t_next = {t_reg[scss_pkg::CARRY_BIT], 1'b0, t_reg[scss_pkg::WORD_W-1:1]};
        end
        scss_pkg::MULTIPLY_STEP_OP: begin
          // Sum or plain top, shifted right together with the address pair
          t_next = {1'b0, mul_sel[scss_pkg::CARRY_BIT:1]};
          a_next = {a_reg[scss_pkg::CARRY_BIT], mul_sel[0], a_reg[scss_pkg::WORD_W-1:1]};
        end
        scss_pkg::XOR_OP: begin
          s_pop = 1'b1;
          t_next = t_reg ^ s_top;
        end
        scss_pkg::AND_OP: begin
          s_pop = 1'b1;
          t_next = t_reg & s_top;
        end
        scss_pkg::DIVIDE_STEP_OP: begin
          if (sum[scss_pkg::CARRY_BIT]) begin
            t_next = {sum[scss_pkg::WORD_W-1:0], a_reg[scss_pkg::WORD_W-1]};
            a_next = {a_reg[scss_pkg::CARRY_BIT], a_reg[scss_pkg::WORD_W-2:0], 1'b1};
          end else begin
            t_next = {t_reg[scss_pkg::WORD_W-1:0], a_reg[scss_pkg::WORD_W-1]};
            a_next = {a_reg[scss_pkg::CARRY_BIT], a_reg[scss_pkg::WORD_W-2:0], 1'b0};
          end
        end
        scss_pkg::ADD_OP: begin
          s_pop = 1'b1;
          t_next = sum;
        end
        scss_pkg::POP_RETURN_OP: begin
          s_push = 1'b1;
          r_pop = 1'b1;
          t_next = r_top;
        end
        scss_pkg::COPY_ADDRESS_OP: begin
          s_push = 1'b1;
          t_next = a_reg;
        end
        scss_pkg::DUP_OP: begin
          s_push = 1'b1;
        end
        scss_pkg::OVER_OP: begin
          s_push = 1'b1;
          t_next = s_top;
        end
        scss_pkg::PUSH_RETURN_OP: begin
          r_push = 1'b1;
          s_pop = 1'b1;
          t_next = s_top;
        end
        scss_pkg::STORE_ADDRESS_OP: begin
          a_next = t_reg;
          s_pop = 1'b1;
          t_next = s_top;
        end
        scss_pkg::DROP_OP: begin
          s_pop = 1'b1;
          t_next = s_top;
        end
        default: begin
          t_next = t_reg;
        end
      endcase
    end
  end

  // long words end after slot one via the transfer codes
  assign code_next = code_sel(i_next, slot_next);

  // Bus outputs registered one cycle ahead of the slot that uses them
  always_comb begin
    // program counter while fetching, in call words or for inline loads
    if (slot_next == scss_pkg::SLOT_FETCH || !i_next[scss_pkg::CALL_FLAG_BIT] ||
        code_next == scss_pkg::LOAD_INLINE_OP) begin
      addr_next = p_next;
    end else begin
      addr_next = a_next[scss_pkg::WORD_W-1:0];
    end
    dout_next = t_next[scss_pkg::WORD_W-1:0];
    wr_next = slot_next != scss_pkg::SLOT_FETCH && i_next[scss_pkg::CALL_FLAG_BIT] &&
              (code_next == scss_pkg::STORE_OP || code_next == scss_pkg::STORE_POST_INC_OP);
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      slot_reg <= scss_pkg::SLOT_FETCH;
      i_reg <= scss_pkg::RESET_VECTOR;
      p_reg <= scss_pkg::RESET_VECTOR;
      a_reg <= scss_pkg::CELL_ZERO;
      t_reg <= scss_pkg::CELL_ZERO;
      ie_reg <= 1'b0;
      addr_reg <= scss_pkg::RESET_VECTOR;
      dout_reg <= scss_pkg::RESET_VECTOR;
      wr_reg <= 1'b0;
    end else begin
      slot_reg <= slot_next;
      i_reg <= i_next;
      p_reg <= p_next;
      a_reg <= a_next;
      t_reg <= t_next;
      ie_reg <= ie_next;
      addr_reg <= addr_next;
      dout_reg <= dout_next;
      wr_reg <= wr_next;
    end
  end

  assign ADDR_BUS = addr_reg;
  assign DATA_OUT = dout_reg;
  assign WRITE_EN = wr_reg;
  assign SLOT = slot_reg;
  assign INT_ENABLED = ie_reg;
endmodule
`default_nettype wire

// ### test/scss_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module scss_core_checker (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic [15:0] DATA_IN,
  input wire logic [4:0] IRQ,
  input wire logic [15:0] ADDR_BUS,
  input wire logic [15:0] DATA_OUT,
  input wire logic WRITE_EN,
  input wire logic [1:0] SLOT,
  input wire logic INT_ENABLED
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);

  a_reset_slot: assert property (disable iff (1'b0) !ARST_N |-> SLOT == 2'h0 && !WRITE_EN && !INT_ENABLED)
    else $error("slot or flags not cleared in reset");
  a_slot_step: assert property (SLOT != 2'h0 |=> SLOT == 2'h0 || SLOT == $past(SLOT) + 2'h1)
    else $error("slot counter skipped a step");
  a_fetch_next: assert property (ARST_N && SLOT == 2'h0 && !INT_ENABLED |=> SLOT == 2'h1)
    else $error("fetch slot not followed by slot one");
  a_fetch_no_write: assert property (SLOT == 2'h0 |-> !WRITE_EN)
    else $error("write strobe during fetch slot");
  a_fetch_soon: assert property (SLOT != 2'h0 |-> ##[1:3] SLOT == 2'h0)
    else $error("word ran past three slots");
  a_irq_vector: assert property (ARST_N && SLOT == 2'h0 ##1 SLOT == 2'h0 |-> !INT_ENABLED &&
    ADDR_BUS[15:5] == 11'h000 && ADDR_BUS[4:0] != 5'h00)
    else $error("interrupt fetch outside vector range");
  a_irq_clear: assert property ($fell(INT_ENABLED) |-> SLOT == 2'h0 && $past(SLOT) == 2'h0)
    else $error("enable dropped without vectored call");
  a_enable_slot: assert property ($rose(INT_ENABLED) |-> $past(SLOT) != 2'h0)
    else $error("enable set by a fetch slot");

  c_interrupt: cover property (ARST_N && SLOT == 2'h0 ##1 SLOT == 2'h0);
  c_write: cover property (WRITE_EN);
  c_slot_three: cover property (SLOT == 2'h3);
  c_enable: cover property ($rose(INT_ENABLED));
endmodule

bind scss_core scss_core_checker chk (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .DATA_IN(DATA_IN), .IRQ(IRQ),
  .ADDR_BUS(ADDR_BUS), .DATA_OUT(DATA_OUT), .WRITE_EN(WRITE_EN), .SLOT(SLOT), .INT_ENABLED(INT_ENABLED));
`default_nettype wire

// ### test/scss_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module scss_mem_model (
  input wire logic CLK_SYS,
  input wire logic [15:0] ADDR_BUS,
  input wire logic [15:0] DATA_OUT,
  input wire logic WRITE_EN,
  output logic [15:0] DATA_IN
);
  logic [15:0] image [0:1023];
  // Low page holds reset and vectors
  // Outside the modelled page the bus shows a moving pattern
  assign DATA_IN = ADDR_BUS[15:10] == 6'h00 ? image[ADDR_BUS[9:0]] : ~ADDR_BUS;
  always @(posedge CLK_SYS) begin
    if (WRITE_EN) begin
      image[ADDR_BUS[9:0]] <= DATA_OUT;
    end
  end
endmodule
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys;
  logic arst_n;
  logic [4:0] irq;
  logic [15:0] data_in;
  logic [15:0] addr_bus;
  logic [15:0] data_out;
  logic write_en;
  logic int_enabled;
  logic [1:0] slot;
  int err_total;
  int n_checks;
  logic [15:0] prog [$];
  logic [15:0] fq [$];
  logic eq [$];
  logic [1:0] sq [$];

  scss_core #(.STACK_DEPTH(32)) dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .DATA_IN(data_in), .IRQ(irq),
    .ADDR_BUS(addr_bus), .DATA_OUT(data_out), .WRITE_EN(write_en), .SLOT(slot), .INT_ENABLED(int_enabled));
  scss_mem_model mem (.CLK_SYS(clk_sys), .ADDR_BUS(addr_bus), .DATA_OUT(data_out), .WRITE_EN(write_en),
    .DATA_IN(data_in));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  function automatic logic [15:0] sw(input logic [4:0] a, input logic [4:0] b, input logic [4:0] c);
    return {1'b1, a, b, c};
  endfunction

  function automatic logic [15:0] lw(input logic [4:0] op, input logic [9:0] t);
    return {1'b1, op, t};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_slot(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  // Reset the core and load the program image while it is held
  task automatic restart();
    @(posedge clk_sys);
    arst_n <= 1'b0;
    @(negedge clk_sys);
    foreach (mem.image[i]) mem.image[i] = i < prog.size() ? prog[i] : 16'hffff;
  endtask

  task automatic go();
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
  endtask

  task automatic run(input int n);
    fq.delete();
    eq.delete();
    sq.delete();
    repeat (n) begin
      @(negedge clk_sys);
      sq.push_back(slot);
      if (slot === 2'h0) begin
        fq.push_back(addr_bus);
        eq.push_back(int_enabled);
      end
    end
  endtask

  task automatic await(input bit want_write);
    int i;
    for (i = 0; i < 12; i++) begin
      @(negedge clk_sys);
      if (want_write ? write_en === 1'b1 : slot === 2'h0) break;
    end
    if (i == 12) begin
      err_total++;
      $display("unexpected wait: expected event seen none");
      tally_and_finish();
    end
  endtask

  task automatic sc_sequence();
    prog = '{sw(scss_pkg::DUP_OP, scss_pkg::DUP_OP, scss_pkg::DUP_OP)};
    restart();
    go();
    run(6);
    for (int i = 0; i < 6; i++) chk_slot("slot", 2'(i % 4), sq[i]);
    chk_word("first fetch", 16'h0000, fq[0]);
    chk_word("second fetch", 16'h0001, fq[1]);
  endtask

  task automatic sc_idle();
    logic [4:0] c [3];
    for (int k = 0; k < 3; k++) begin
      for (int j = 0; j < 3; j++) c[j] = j == k ? scss_pkg::IDLE_OP : scss_pkg::DUP_OP;
      prog = '{sw(c[0], c[1], c[2])};
      restart();
      go();
      run(k + 3);
      chk_slot("slot after idle", 2'h0, sq[k + 2]);
      chk_word("fetch after idle", 16'h0001, fq[1]);
    end
  endtask

  task automatic sc_branch();
    logic [4:0] ops [3] = '{scss_pkg::BRANCH_OP, scss_pkg::BRANCH_IF_ZERO_OP, scss_pkg::BRANCH_IF_CARRY_OP};
    logic [15:0] dst [3] = '{16'h0020, 16'h0020, 16'h0001};
    for (int k = 0; k < 3; k++) begin
      prog = '{lw(ops[k], 10'h020)};
      restart();
      go();
      run(3);
      chk_slot("slot after long", 2'h0, sq[2]);
      chk_word("branch target", dst[k], fq[1]);
    end
  endtask

  task automatic sc_call();
    prog = '{16'h0040};
    restart();
    mem.image[16'h40] = sw(scss_pkg::RETURN_OP, scss_pkg::DUP_OP, scss_pkg::DUP_OP);
    go();
    run(8);
    chk_word("call target", 16'h0040, fq[1]);
    chk_word("return target", 16'h0001, fq[2]);
  endtask

  task automatic sc_loop();
    prog = '{sw(scss_pkg::LOAD_INLINE_OP, scss_pkg::PUSH_RETURN_OP, scss_pkg::IDLE_OP), 16'h0002,
      lw(scss_pkg::LOOP_NEXT_OP, 10'h002)};
    restart();
    go();
    run(12);
    for (int i = 1; i < 4; i++) chk_word("loop fetch", 16'h0002, fq[i]);
    chk_word("loop exit", 16'h0003, fq[4]);
  endtask

  task automatic sc_store();
    prog = '{sw(scss_pkg::LOAD_INLINE_OP, scss_pkg::STORE_ADDRESS_OP, scss_pkg::LOAD_INLINE_OP), 16'h0100,
      16'h5a5a, sw(scss_pkg::STORE_POST_INC_OP, scss_pkg::COPY_ADDRESS_OP, scss_pkg::IDLE_OP)};
    restart();
    go();
    await(1'b1);
    chk_word("store address", 16'h0100, addr_bus);
    chk_word("store data", 16'h5a5a, data_out);
    await(1'b0);
    chk_word("copied address", 16'h0101, data_out);
    chk_word("memory word", 16'h5a5a, mem.image[16'h100]);
    chk_bit("write strobe end", 1'b0, write_en);
  endtask

  task automatic sc_alu();
    prog = '{sw(scss_pkg::LOAD_INLINE_OP, scss_pkg::LOAD_INLINE_OP, scss_pkg::ADD_OP), 16'h1234, 16'h0101,
      sw(scss_pkg::COMPLEMENT_OP, scss_pkg::STORE_OP, scss_pkg::IDLE_OP)};
    restart();
    go();
    await(1'b1);
    chk_word("alu result", 16'hecca, data_out);
    chk_word("alu address", 16'h0000, addr_bus);
  endtask

  task automatic sc_interrupt();
    int hits;
    int at;
    hits = 0;
    at = 0;
    prog = '{sw(scss_pkg::INTERRUPT_ENABLE_OP, scss_pkg::IDLE_OP, scss_pkg::IDLE_OP),
      lw(scss_pkg::BRANCH_OP, 10'h001)};
    restart();
    mem.image[7] = sw(scss_pkg::RETURN_OP, scss_pkg::IDLE_OP, scss_pkg::IDLE_OP);
    @(posedge clk_sys);
    irq <= 5'h07;
    go();
    run(40);
    chk_bit("enable before op", 1'b0, eq[0]);
    chk_bit("enable after op", 1'b1, eq[1]);
    foreach (fq[i]) begin
      if (fq[i] === 16'h0007) begin
        hits++;
        at = i;
      end
    end
    chk_word("vector entries", 16'h0001, 16'(hits));
    chk_word("interrupted fetch", 16'h0001, fq[at - 1]);
    chk_word("resumed fetch", 16'h0001, fq[at + 1]);
    chk_bit("enable after entry", 1'b0, int_enabled);
    @(posedge clk_sys);
    irq <= 5'h00;
  endtask

  initial begin
    arst_n = 1'b0;
    irq = 5'h00;
    err_total = 0;
    n_checks = 0;
    sc_sequence();
    sc_idle();
    sc_branch();
    sc_call();
    sc_loop();
    sc_store();
    sc_alu();
    sc_interrupt();
    tally_and_finish();
  end
endmodule
`default_nettype wire
